//--- rtl/twf_formatter.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - enable follows decoded transfer function
// - sequencer runs only when enabled and started
// - go gives start pulse, edge pulse, preset
// - preset sends two separate word requests
// - both halves load into 48-bit shift register
// - first word prompt, later after conversion
// - decode format into frames per word
// - undefined format code raises format error
// - compatibility: four 8-bit frames, bits 0-31
// - core dump: fifth frame bits 32-35 low
// - ASCII: 7-bit frames, fifth carries bit 35
// - seven-track: six bits on tracks 5-0
// - seven-track sixth frame bits 30-35
// - shift clock delayed per format
// - NRZ: one strobe per drive write clock
// - PE: strobe in data gate, half rate
// - each strobe in run state outputs frame, ticks count
// - count reached requests next word
// - no request after final word
// - parity checked on each second-half load
// - strobe before host answer on later words: timing error
// - seven-track under PE is format error
module twf_formatter
    import twf_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire twf_pkg::twf_pins_t pins_in,
    input wire twf_pkg::twf_half_t host_half,
    output logic formatter_enable,
    output logic drive_start_pulse,
    output logic start_edge_pulse,
    output logic word_request_pulse,
    output logic shift_register_clock,
    output logic record_write_active,
    output logic char_write_strobe,
    output logic frame_count_tick,
    output logic [7:0] frame_data,
    output logic set_bus_parity_error,
    output logic set_timing_error
);
    import twf_pkg::*;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [2:0] frames_of(input logic [3:0] f);
        logic [2:0] n;
        n = TWF_FRAMES_COMPAT;
        if (f == TWF_FMT_CORE) n = TWF_FRAMES_CORE;
        else if (f == TWF_FMT_SEVEN) n = TWF_FRAMES_SEVEN;
        else if (f == TWF_FMT_ASCII) n = TWF_FRAMES_ASCII;
        return n;
    endfunction

    function automatic logic [3:0] width_of(input logic [3:0] f);
        logic [3:0] w;
        w = 4'h8;
        if (f == TWF_FMT_SEVEN) w = 4'h6;
        else if (f == TWF_FMT_ASCII) w = 4'h7;
        return w;
    endfunction

    // Lowest word bit lands on the highest used track, except the ASCII fifth frame, where it lands on track 6 below bit 35
    function automatic logic [7:0] frame_of(input logic [47:0] sr,
        input logic [3:0] f, input logic last);
        logic [7:0] o;
        o = 8'h00;
        if (f == TWF_FMT_CORE && last) begin
            for (int i = 0; i < 4; i++) o[3 - i] = sr[i];
        end else if (f == TWF_FMT_ASCII) begin
            for (int i = 0; i < 7; i++) o[6 - i] = sr[i];
            if (last) o[7] = sr[7];
        end else if (f == TWF_FMT_SEVEN) begin
            for (int i = 0; i < 6; i++) o[5 - i] = sr[i];
        end else begin
            for (int i = 0; i < 8; i++) o[7 - i] = sr[i];
        end
        return o;
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    twf_pins_t pins_s1_q, pins_s2_q;
    twf_half_t half_s1_q, half_s2_q;
    logic go_prev_q, wstb_prev_q, wclk_prev_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
            half_s1_q <= '0;
            half_s2_q <= '0;
            go_prev_q <= 1'b0;
            wstb_prev_q <= 1'b0;
            wclk_prev_q <= 1'b0;
        end else begin
            pins_s1_q <= pins_in;
            pins_s2_q <= pins_s1_q;
            half_s1_q <= host_half;
            half_s2_q <= half_s1_q;
            go_prev_q <= pins_s2_q.transfer_go;
            wstb_prev_q <= pins_s2_q.word_strobe_pulse;
            wclk_prev_q <= pins_s2_q.drive_write_clock;
        end
    end

    wire go_rise = pins_s2_q.transfer_go & ~go_prev_q;
    wire wstb_rise = pins_s2_q.word_strobe_pulse & ~wstb_prev_q;
    wire wclk_rise = pins_s2_q.drive_write_clock & ~wclk_prev_q;

    // ************************************************************
    // Registers and APB slave
    // ************************************************************
    logic [31:0] ctrl_q;
    logic [15:0] words_q;
    logic format_error_flag_q, bus_parity_error_flag_q, dte_q;
    logic [15:0] frame_cnt_q;
    twf_state_t state_q, state_d;

    wire wr_en = psel & penable & pwrite;
    wire sel_ctrl = (paddr == TWF_CTRL_ADDR);
    wire sel_words = (paddr == TWF_WORDS_ADDR);
    wire sel_status = (paddr == TWF_STATUS_ADDR);
    wire sel_frames = (paddr == TWF_FRAMES_ADDR);
    wire mapped = sel_ctrl | sel_words | sel_status | sel_frames;
    wire clr_format_error_flag = wr_en & sel_status & pwdata[TWF_ST_FORMAT_ERROR_FLAG_BIT];
    wire clr_bus_parity_error_flag = wr_en & sel_status & pwdata[TWF_ST_BUS_PARITY_ERROR_FLAG_BIT];
    wire clr_dte = wr_en & sel_status & pwdata[TWF_ST_DTE_BIT];

    wire [3:0] cfg_fmt = ctrl_q[TWF_CTRL_FMT_LSB +: TWF_FMT_W];
    wire cfg_pe = ctrl_q[TWF_CTRL_PE_BIT];
    wire busy = (state_q != TWF_IDLE);

    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[TWF_ST_FORMAT_ERROR_FLAG_BIT] = format_error_flag_q;
        status_word[TWF_ST_BUS_PARITY_ERROR_FLAG_BIT] = bus_parity_error_flag_q;
        status_word[TWF_ST_DTE_BIT] = dte_q;
        status_word[TWF_ST_WDR_BIT] = record_write_active;
        status_word[TWF_ST_BUSY_BIT] = busy;
    end

    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_q :
        sel_words ? {16'h0000, words_q} :
        sel_status ? status_word :
        sel_frames ? {16'h0000, frame_cnt_q} : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = rd_mux;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= TWF_CTRL_RESET;
            words_q <= TWF_WORDS_RESET;
        end else if (wr_en && sel_ctrl) begin
            ctrl_q <= pwdata;
        end else if (wr_en && sel_words) begin
            words_q <= pwdata[15:0];
        end
    end

    assign formatter_enable = ctrl_q[TWF_CTRL_OCC_BIT];

    // ************************************************************
    // Record sequencer
    // ************************************************************
    logic start_latched_q;
    logic [3:0] fmt_q;
    logic [2:0] fidx_q;
    logic [3:0] dly_q;
    logic [15:0] words_left_q;
    logic [47:0] sr_q;
    logic strobe_q, tick_q, first_q, wdr_q;
    logic [7:0] frame_q;

    // Strobe source differs per recording mode
    wire nrz_strobe = wclk_rise & wdr_q & ~cfg_pe;
    wire pe_strobe = wclk_rise & wdr_q & cfg_pe
        & pins_s2_q.encoded_data_write_gate
        & pins_s2_q.data_phase_half_clock;
    wire strobe_now = nrz_strobe | pe_strobe;

    wire fmt_bad = (cfg_fmt > TWF_FMT_COMPAT);
    wire pe_seven = cfg_pe & (cfg_fmt == TWF_FMT_SEVEN);
    wire run_ok = formatter_enable & start_latched_q;
    wire frame_last = (fidx_q == frames_of(fmt_q) - 3'h1);
    wire char_count_match = (state_q == TWF_RUN) & strobe_q & frame_last;
    wire parity_bad = ((^half_s2_q.data) ^ half_s2_q.bus_parity_bit)
        != TWF_PARITY_ODD;
    wire word_pending = (state_q == TWF_REQ1) | (state_q == TWF_WAIT1)
        | (state_q == TWF_REQ2) | (state_q == TWF_WAIT2)
        | (state_q == TWF_SHIFT);
    wire [3:0] dly_sel = (fmt_q == TWF_FMT_SEVEN) ? TWF_DLY_SEVEN :
        (fmt_q == TWF_FMT_ASCII) ? TWF_DLY_ASCII : TWF_DLY_PLAIN;

    always_comb begin
        state_d = state_q;
        case (state_q)
            TWF_IDLE: begin
                if (run_ok && !fmt_bad && !pe_seven) state_d = TWF_START;
            end
            TWF_START: state_d = TWF_EDGE;
            TWF_EDGE: state_d = TWF_REQ1;
            TWF_REQ1: state_d = TWF_WAIT1;
            TWF_WAIT1: begin
                if (wstb_rise) state_d = TWF_REQ2;
            end
            TWF_REQ2: state_d = TWF_WAIT2;
            TWF_WAIT2: begin
                if (wstb_rise) state_d = TWF_SHIFT;
            end
            TWF_SHIFT: begin
                if (dly_q == 4'h0) state_d = TWF_RUN;
            end
            TWF_RUN: begin
                if (!formatter_enable) state_d = TWF_IDLE;
                else if (char_count_match) begin
                    if (words_left_q == 16'h0000) state_d = TWF_IDLE;
                    else state_d = TWF_REQ1;
                end
            end
            default: state_d = TWF_IDLE;
        endcase
    end

    assign drive_start_pulse = (state_q == TWF_START);
    assign start_edge_pulse = (state_q == TWF_EDGE);
    assign word_request_pulse = (state_q == TWF_REQ1)
        | (state_q == TWF_REQ2);
    assign shift_register_clock = (state_q == TWF_SHIFT)
        & (dly_q == 4'h0);
    assign set_bus_parity_error = (state_q == TWF_WAIT2) & wstb_rise
        & parity_bad;
    assign set_timing_error = strobe_q & word_pending & ~first_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= TWF_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            start_latched_q <= 1'b0;
            fmt_q <= TWF_FMT_CORE;
            words_left_q <= 16'h0000;
            first_q <= 1'b0;
            wdr_q <= 1'b0;
            dly_q <= 4'h0;
        end else begin
            if (go_rise && state_q == TWF_IDLE) start_latched_q <= 1'b1;
            else if (state_q == TWF_START) start_latched_q <= 1'b0;
            if (state_q == TWF_START) begin
                fmt_q <= cfg_fmt;
                words_left_q <= words_q;
                first_q <= 1'b1;
                wdr_q <= 1'b1;
            end
            if (state_q == TWF_RUN) first_q <= 1'b0;
            if (state_d == TWF_IDLE) wdr_q <= 1'b0;
            if (state_q == TWF_WAIT2 && wstb_rise
                && words_left_q != 16'h0000) begin
                words_left_q <= words_left_q - 16'h0001;
            end
            if (state_q == TWF_WAIT2) dly_q <= dly_sel;
            else if (dly_q != 4'h0) dly_q <= dly_q - 4'h1;
        end
    end

    // Halves meet in the low 36 bits; upper bits stay clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sr_q <= 48'h0000_0000_0000;
        end else if (state_q == TWF_WAIT1 && wstb_rise) begin
            sr_q <= {30'h0000_0000, half_s2_q.data};
        end else if (state_q == TWF_WAIT2 && wstb_rise) begin
            sr_q <= {12'h000, half_s2_q.data, sr_q[17:0]};
        end else if (state_q == TWF_RUN && strobe_q) begin
            sr_q <= sr_q >> width_of(fmt_q);
        end
    end

    // ************************************************************
    // Frame output
    // ************************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strobe_q <= 1'b0;
            tick_q <= 1'b0;
            frame_q <= 8'h00;
            fidx_q <= 3'h0;
            frame_cnt_q <= 16'h0000;
        end else begin
            strobe_q <= strobe_now;
            tick_q <= (state_q == TWF_RUN) & strobe_q;
            if (state_q == TWF_START) frame_cnt_q <= 16'h0000;
            if (state_q == TWF_REQ1) fidx_q <= 3'h0;
            if (state_q == TWF_RUN && strobe_q) begin
                frame_q <= frame_of(sr_q, fmt_q, frame_last);
                frame_cnt_q <= frame_cnt_q + 16'h0001;
                fidx_q <= fidx_q + 3'h1;
            end
        end
    end

    assign char_write_strobe = strobe_q;
    assign frame_count_tick = tick_q;
    assign frame_data = frame_q;
    assign record_write_active = wdr_q;

    // ************************************************************
    // Error flags: a set in the clearing cycle wins
    // ************************************************************
    wire set_format_error_flag = (state_q == TWF_IDLE) & run_ok & (fmt_bad | pe_seven);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            format_error_flag_q <= 1'b0;
            bus_parity_error_flag_q <= 1'b0;
            dte_q <= 1'b0;
        end else begin
            format_error_flag_q <= (format_error_flag_q & ~clr_format_error_flag) | set_format_error_flag;
            bus_parity_error_flag_q <= (bus_parity_error_flag_q & ~clr_bus_parity_error_flag) | set_bus_parity_error;
            dte_q <= (dte_q & ~clr_dte) | set_timing_error;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_enable_follows: assert property (@(posedge core_clk)
        disable iff (!nrst) formatter_enable == ctrl_q[TWF_CTRL_OCC_BIT])
        else $error("enable does not follow control bit");
    chk_start_gated: assert property (@(posedge core_clk)
        disable iff (!nrst) $rose(drive_start_pulse) |-> $past(run_ok))
        else $error("start without enable and latch");
    chk_start_order: assert property (@(posedge core_clk)
        disable iff (!nrst)
        drive_start_pulse |=> start_edge_pulse ##1 word_request_pulse)
        else $error("start pulse order wrong");
    chk_two_requests: assert property (@(posedge core_clk)
        disable iff (!nrst)
        word_request_pulse |=> !word_request_pulse)
        else $error("word requests not separate");
    chk_format_error: assert property (@(posedge core_clk)
        disable iff (!nrst) set_format_error_flag |=> format_error_flag_q && state_q == TWF_IDLE)
        else $error("bad format not flagged");
    chk_tick_strobe: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (state_q == TWF_RUN && strobe_q) |=> frame_count_tick)
        else $error("frame tick missing");
    chk_last_word: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (char_count_match && words_left_q == 16'h0000)
        |=> !word_request_pulse [*2])
        else $error("request after last word");
    chk_timing_err: assert property (@(posedge core_clk)
        disable iff (!nrst) set_timing_error |=> dte_q)
        else $error("timing error flag not set");
    chk_parity_err: assert property (@(posedge core_clk)
        disable iff (!nrst) set_bus_parity_error |=> bus_parity_error_flag_q)
        else $error("parity flag not set");
    chk_fmt_held: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (state_q == TWF_RUN && $past(state_q) == TWF_RUN)
        |-> $stable(fmt_q))
        else $error("format changed mid record");

endmodule

`default_nettype wire

//--- rtl/twf_pkg.sv
package twf_pkg;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] TWF_CTRL_ADDR = 8'h00;
    localparam logic [7:0] TWF_WORDS_ADDR = 8'h04;
    localparam logic [7:0] TWF_STATUS_ADDR = 8'h08;
    localparam logic [7:0] TWF_FRAMES_ADDR = 8'h0C;

    // Control field positions
    localparam int TWF_CTRL_OCC_BIT = 0;
    localparam int TWF_CTRL_PE_BIT = 1;
    localparam int TWF_CTRL_FMT_LSB = 4;
    localparam int TWF_FMT_W = 4;

    // Status field positions
    localparam int TWF_ST_FORMAT_ERROR_FLAG_BIT = 0;
    localparam int TWF_ST_BUS_PARITY_ERROR_FLAG_BIT = 1;
    localparam int TWF_ST_DTE_BIT = 2;
    localparam int TWF_ST_WDR_BIT = 3;
    localparam int TWF_ST_BUSY_BIT = 4;

    localparam logic [31:0] TWF_CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] TWF_WORDS_RESET = 16'h0001;

    // ************************************************************
    // Formats
    // ************************************************************
    localparam logic [3:0] TWF_FMT_CORE = 4'h0;
    localparam logic [3:0] TWF_FMT_SEVEN = 4'h1;
    localparam logic [3:0] TWF_FMT_ASCII = 4'h2;
    localparam logic [3:0] TWF_FMT_COMPAT = 4'h3;

    localparam logic [2:0] TWF_FRAMES_CORE = 3'h5;
    localparam logic [2:0] TWF_FRAMES_SEVEN = 3'h6;
    localparam logic [2:0] TWF_FRAMES_ASCII = 3'h5;
    localparam logic [2:0] TWF_FRAMES_COMPAT = 3'h4;

    // Shift-clock delay per format, in ns, and in 100 MHz cycles
    localparam int TWF_CLK_NS = 10;
    localparam int TWF_DLY_PLAIN_NS = 20;
    localparam int TWF_DLY_ASCII_NS = 50;
    localparam int TWF_DLY_SEVEN_NS = 70;
    localparam logic [3:0] TWF_DLY_PLAIN =
        4'((TWF_DLY_PLAIN_NS + TWF_CLK_NS - 1) / TWF_CLK_NS);
    localparam logic [3:0] TWF_DLY_ASCII =
        4'((TWF_DLY_ASCII_NS + TWF_CLK_NS - 1) / TWF_CLK_NS);
    localparam logic [3:0] TWF_DLY_SEVEN =
        4'((TWF_DLY_SEVEN_NS + TWF_CLK_NS - 1) / TWF_CLK_NS);

    // Odd parity across the 18 data lines plus the parity line
    localparam logic TWF_PARITY_ODD = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic bus_parity_bit;
        logic [17:0] data;
    } twf_half_t;

    typedef struct packed {
        logic transfer_go;
        logic word_strobe_pulse;
        logic drive_write_clock;
        logic encoded_data_write_gate;
        logic data_phase_half_clock;
    } twf_pins_t;

    typedef enum logic [8:0] {
        TWF_IDLE = 9'b0_0000_0001,
        TWF_START = 9'b0_0000_0010,
        TWF_EDGE = 9'b0_0000_0100,
        TWF_REQ1 = 9'b0_0000_1000,
        TWF_WAIT1 = 9'b0_0001_0000,
        TWF_REQ2 = 9'b0_0010_0000,
        TWF_WAIT2 = 9'b0_0100_0000,
        TWF_SHIFT = 9'b0_1000_0000,
        TWF_RUN = 9'b1_0000_0000
    } twf_state_t;

endpackage

//--- verification/tb_tape_word_write_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tape_word_write_formatter;
    import twf_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    localparam int C_REQ = 0, C_SH = 1, C_DS = 2, C_STR = 3;
    localparam int C_RISE = 4, C_PERR = 5, C_TERR = 6;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, frame_data, lag;
    logic [31:0] pwdata, prdata, rd;
    twf_pins_t pins_in;
    twf_half_t host_half;
    logic formatter_enable, drive_start_pulse, start_edge_pulse;
    logic word_request_pulse, shift_register_clock, record_write_active;
    logic char_write_strobe, frame_count_tick, set_bus_parity_error;
    logic set_timing_error, go, wstb, wclk, gate, hclk, run, nogate;
    logic hbusy, bad_par;
    logic [35:0] seed;
    logic [7:0] frames[$];
    int cnt[7];
    int n_mismatch, tests_run;
    assign pins_in = {go, wstb, wclk, gate, hclk};
    twf_formatter dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pins_in, .host_half,
        .formatter_enable, .drive_start_pulse, .start_edge_pulse,
        .word_request_pulse, .shift_register_clock, .record_write_active,
        .char_write_strobe, .frame_count_tick, .frame_data,
        .set_bus_parity_error, .set_timing_error);
    twf_host_model host (.core_clk, .nrst, .word_request_pulse, .seed,
        .bad_par, .lag, .strobe(wstb), .half(host_half), .busy(hbusy));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Unless nogate is set, the drive clock holds still while the host is still answering
    initial begin
        wclk = 1'b0;
        hclk = 1'b0;
        #3;
        forever begin
            #62.5;
            wait (run && (nogate || !hbusy));
            #1;
            wclk = 1'b1;
            cnt[C_RISE]++;
            #62.5;
            wclk = 1'b0;
            hclk = ~hclk;
        end
    end
    always @(posedge core_clk) begin
        if (frame_count_tick === 1'b1) frames.push_back(frame_data);
        if (word_request_pulse === 1'b1) cnt[C_REQ]++;
        if (shift_register_clock === 1'b1) cnt[C_SH]++;
        if (drive_start_pulse === 1'b1) cnt[C_DS]++;
        if (char_write_strobe === 1'b1) cnt[C_STR]++;
        if (set_bus_parity_error === 1'b1) cnt[C_PERR]++;
        if (set_timing_error === 1'b1) cnt[C_TERR]++;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic int nfr(input logic [3:0] f);
        return (f == TWF_FMT_SEVEN) ? 6 : (f == TWF_FMT_COMPAT) ? 4 : 5;
    endfunction
    function automatic logic [7:0] expf(input logic [3:0] f,
                                        input logic [35:0] w, input int i);
        logic [7:0] r;
        r = 8'h00;
        if (f == TWF_FMT_SEVEN) begin
            for (int j = 0; j < 6; j++) r[5 - j] = w[6 * i + j];
        end else if (f == TWF_FMT_ASCII) begin
            for (int j = 0; j < 7; j++) r[6 - j] = w[7 * i + j];
            if (i == 4) r[7] = w[35];
        end else if (i == 4) begin
            for (int j = 0; j < 4; j++) r[3 - j] = w[32 + j];
        end else begin
            for (int j = 0; j < 8; j++) r[7 - j] = w[8 * i + j];
        end
        return r;
    endfunction
    task automatic record(input logic [7:0] ctrl, input int words);
        int t;
        @(posedge core_clk);
        nrst <= 1'b0;
        frames.delete();
        cnt = '{default: 0};
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        apb(1'b1, TWF_WORDS_ADDR, 32'(words));
        apb(1'b1, TWF_CTRL_ADDR, {24'h0, ctrl});
        // The write lands at the edge the task returns on
        @(posedge core_clk);
        chk(formatter_enable, ctrl[0]);
        go <= 1'b1;
        repeat (4) @(posedge core_clk);
        go <= 1'b0;
        run <= 1'b1;
        t = 0;
        while (frames.size() < words * nfr(ctrl[7:4]) && t < 4000) begin
            @(posedge core_clk);
            t++;
        end
        repeat (150) @(posedge core_clk);
        run <= 1'b0;
    endtask
    task automatic check_frames(input logic [3:0] f, input int words);
        int n;
        n = nfr(f);
        chk(frames.size(), words * n);
        for (int k = 0; k < words; k++) begin
            for (int i = 0; i < n; i++) begin
                chk(frames[k * n + i], expf(f, seed + 36'h2_4924_9249 * k, i));
            end
        end
    endtask
    initial begin
        #800000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {nrst, psel, penable, pwrite, go, gate, run, nogate} = 8'h00;
        {paddr, pwdata, bad_par, lag} = '0;
        seed = 36'h9_A5C3_1E7B;
        n_mismatch = 0;
        tests_run = 0;
        record(8'h30, 0);
        chk(cnt[C_DS] + cnt[C_REQ], 0);
        apb(1'b0, TWF_WORDS_ADDR, 32'h0);
        // The record above wrote zero words
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
        $display("test idle and registers done");
        for (int f = 0; f < 4; f++) begin
            record({4'(f), 4'h1}, 2);
            check_frames(4'(f), 2);
            chk(cnt[C_REQ], 4);
            chk(cnt[C_SH] * 16 + cnt[C_DS], 33);
            apb(1'b0, TWF_STATUS_ADDR, 32'h0);
            chk(rd[4:0], 5'h00);
            $display("test format %0d done", f);
        end
        gate <= 1'b1;
        record(8'h23, 1);
        check_frames(TWF_FMT_ASCII, 1);
        chk(cnt[C_STR] * 2 <= cnt[C_RISE], 1'b1);
        gate <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            record(i ? 8'h13 : 8'h51, 0);
            apb(1'b0, TWF_STATUS_ADDR, 32'h0);
            chk({cnt[C_DS], rd[0]}, 1);
        end
        $display("test format refusal done");
        bad_par <= 1'b1;
        record(8'h31, 1);
        bad_par <= 1'b0;
        apb(1'b0, TWF_STATUS_ADDR, 32'h0);
        chk({cnt[C_PERR], rd[1]}, 3);
        apb(1'b1, TWF_STATUS_ADDR, 32'h2);
        apb(1'b0, TWF_STATUS_ADDR, 32'h0);
        chk(rd[1], 1'b0);
        $display("test parity done");
        nogate <= 1'b1;
        lag <= 8'h28;
        record(8'h31, 2);
        apb(1'b0, TWF_STATUS_ADDR, 32'h0);
        chk({cnt[C_TERR] > 0, rd[2]}, 2'h3);
        $display("test timing done");
        stop_test();
    end
endmodule
`default_nettype wire

//--- verification/twf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module twf_host_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic word_request_pulse,
    input wire logic [35:0] seed,
    input wire logic bad_par,
    input wire logic [7:0] lag,
    output logic strobe,
    output twf_pkg::twf_half_t half,
    output logic busy
);
    import twf_pkg::*;
    // ****************************************
    // One half-word answered per request
    // ****************************************
    int nreq;
    int nsrv;
    int idle;
    logic [35:0] w;
    logic [17:0] d;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            nreq <= 0;
        end else if (word_request_pulse) begin
            nreq <= nreq + 1;
        end
    end
    initial begin
        strobe = 1'b0;
        half = '0;
        busy = 1'b0;
        nsrv = 0;
        idle = 20;
        forever begin
            @(posedge core_clk);
            if (!nrst) begin
                nsrv = 0;
                busy <= 1'b0;
            end else if (nsrv < nreq) begin
                busy <= 1'b1;
                idle = 0;
                repeat (lag) @(posedge core_clk);
                w = seed + 36'h2_4924_9249 * (nsrv / 2);
                d = nsrv[0] ? w[35:18] : w[17:0];
                half <= {~^d ^ bad_par, d};
                repeat (3) @(posedge core_clk);
                strobe <= 1'b1;
                repeat (4) @(posedge core_clk);
                strobe <= 1'b0;
                repeat (4) @(posedge core_clk);
                // Released lines must not keep showing stale data
                half <= ~half;
                nsrv = nsrv + 1;
            end else if (idle < 12) begin
                idle = idle + 1;
                busy <= idle < 12;
            end
        end
    end
endmodule
`default_nettype wire
